/* File: rtl/lfg_pkg.sv */
// constants for led fault reporting and output gating
// Contract
// - fault code 00 none, 01 short, 10 open
// - open flagged when on and current low
// - open threshold half target, per gain
// - detect only while on; off reads zero only when keep detecting
// - short flagged when output voltage high
// - short bit zero while voltage low
// - overtemperature disables all outputs until cooled
// - overtemperature sets overheat flag bit 7
// - recovery restores state, flag self-clears
// - gate low enables outputs with delays
// - gate high makes all outputs off
// - reset clears all registers to zero
// - individual pwm 31.25 kHz, 256 steps
// - group dimming 122 Hz duty superimposed
// - group blinking 15 Hz to 16.8 s
// - fault codes packed four per byte
// - summary fault bit 6 in mode register
// - keep detecting live, else latch first
// - test only on, individual, group states
package lfg_pkg;
    localparam int NUM_CH = 24;
    localparam int CH_PER_REG = 4;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CLK_HZ = 20_000_000;
    localparam int PWM_HZ = 31_250;
    localparam int PWM_STEPS = 256;
    localparam logic [9:0] PWM_ACC_STEP = 10'(PWM_STEPS);
    localparam logic [9:0] PWM_ACC_MOD = 10'(CLK_HZ / PWM_HZ);
    localparam int BLINK_PWM_PERIODS = 8;
    localparam logic [11:0] BLINK_PERIODS_W = 12'(BLINK_PWM_PERIODS);
    localparam int DELAY_UNIT_NS = 1000;
    localparam logic [4:0] DELAY_UNIT_CYC = 5'(DELAY_UNIT_NS / CLK_PERIOD_NS);
    localparam logic [9:0] ELAPSED_MAX = 10'h3ff;

    localparam logic [6:0] MODE_CFG_ADDR = 7'h01;
    localparam logic [6:0] FAULT_FLAG_BASE = 7'h02;
    localparam logic [6:0] FAULT_FLAG_LAST = 7'h07;
    localparam logic [6:0] DRIVE_STATE_BASE = 7'h08;
    localparam logic [6:0] DRIVE_STATE_LAST = 7'h0d;
    localparam logic [6:0] PWM_BASE = 7'h0e;
    localparam logic [6:0] PWM_LAST = 7'h25;
    localparam logic [6:0] GROUP_DUTY_ADDR = 7'h26;
    localparam logic [6:0] GROUP_FREQ_ADDR = 7'h27;
    localparam logic [6:0] TURN_ON_OFFSET_ADDR = 7'h28;
    localparam logic [6:0] GAIN_BASE = 7'h29;
    localparam logic [6:0] GAIN_LAST = 7'h40;

    localparam int OVERHEAT_BIT = 7;
    localparam int FAULT_ANY_BIT = 6;
    localparam int GROUP_BLINK_BIT = 5;
    localparam int FAULT_CLEAR_BIT = 4;
    localparam int KEEP_DETECT_BIT = 3;

    localparam logic [1:0] FAULT_NONE = 2'h0;
    localparam logic [1:0] FAULT_SHORT = 2'h1;
    localparam logic [1:0] FAULT_OPEN = 2'h2;

    localparam logic [1:0] DRV_OFF = 2'h0;
    localparam logic [1:0] DRV_ON = 2'h1;
    localparam logic [1:0] DRV_INDIV = 2'h2;
    localparam logic [1:0] DRV_GROUP = 2'h3;

    localparam logic [7:0] PWM_TEST_MIN = 8'h08;
    localparam logic [7:0] PWM_FULL = 8'hff;
    localparam logic [7:0] READ_IDLE = 8'h00;
endpackage

/* File: rtl/lfg_sync.sv */
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module lfg_sync
    import lfg_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } lfg_sync_state_t;

    lfg_sync_state_t st_r;
    lfg_sync_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = async_i;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_o = st_r.stable;
endmodule

/* File: rtl/lfg_led_fault_gate.sv */
// led fault flags, overtemperature and gate-pin output control with pwm dimming
`timescale 1ns/1ps
module lfg_led_fault_gate
    import lfg_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [23:0] open_cmp_i,
    input wire logic [23:0] short_cmp_i,
    input wire logic overheat_flag_i,
    input wire logic out_gate_n_i,
    output logic [23:0] led_sink_o,
    output logic [23:0][7:0] current_gain_o,
    output logic overheat_o,
    output logic fault_any_o
);
    typedef struct packed {
        logic [7:0] rdata;
        logic blink_sel;
        logic keep_det;
        logic [3:0] on_offset;
        logic [7:0] grp_duty;
        logic [7:0] grp_freq;
        logic [23:0][1:0] drv;
        logic [23:0][7:0] pwm;
        logic [23:0][7:0] gain;
        logic [23:0][1:0] fault;
        logic [9:0] acc;
        logic [7:0] pwm_cnt;
        logic [7:0] dim_cnt;
        logic [11:0] blink_pre;
        logic [7:0] blink_cnt;
        logic [4:0] us_pre;
        logic [9:0] elapsed;
        logic [23:0] sink;
    } lfg_state_t;

    lfg_state_t st_r;
    lfg_state_t st_nxt;

    logic [49:0] sync_in;
    logic [49:0] sync_out;
    logic [23:0] open_s;
    logic [23:0] short_s;
    logic hot_s;
    logic gate_n_s;
    logic fault_any;

    function automatic logic in_range(input logic [6:0] a, input logic [6:0] lo, input logic [6:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [4:0] reg_index(input logic [6:0] a, input logic [6:0] base);
        logic [6:0] d;
        d = a - base;
        return d[4:0];
    endfunction

    // comparators and gate pin cross into the clock domain here
    assign sync_in = {out_gate_n_i, overheat_flag_i, short_cmp_i, open_cmp_i};

    lfg_sync #(
        .WIDTH(50)
    ) lfg_sync_i (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .async_i(sync_in),
        .sync_o(sync_out)
    );

    assign open_s = sync_out[23:0];
    assign short_s = sync_out[47:24];
    assign hot_s = sync_out[48];
    assign gate_n_s = sync_out[49];

    assign fault_any = |st_r.fault;

    always_comb begin
        logic [9:0] acc_sum;
        logic pwm_tick;
        logic period_end;
        logic [11:0] blink_len;
        logic grp_on;
        logic pwm_on;
        logic base_on;
        logic gate_ok;
        logic detect_ok;
        logic halt;
        logic fault_clear;
        logic [1:0] code;
        logic [4:0] idx;
        logic [7:0] rd;
        logic [9:0] threshold;
        int ch;

        acc_sum = 10'h000;
        pwm_tick = 1'b0;
        period_end = 1'b0;
        blink_len = 12'h000;
        grp_on = 1'b0;
        pwm_on = 1'b0;
        base_on = 1'b0;
        gate_ok = 1'b0;
        detect_ok = 1'b0;
        halt = 1'b0;
        fault_clear = 1'b0;
        code = FAULT_NONE;
        idx = 5'h00;
        rd = READ_IDLE;
        threshold = 10'h000;
        ch = 0;
        st_nxt = st_r;

        // register writes
        if (reg_wr_i) begin
            idx = 5'h00;
            if (reg_addr_i == MODE_CFG_ADDR) begin
                st_nxt.blink_sel = reg_wdata_i[GROUP_BLINK_BIT];
                st_nxt.keep_det = reg_wdata_i[KEEP_DETECT_BIT];
                fault_clear = reg_wdata_i[FAULT_CLEAR_BIT];
            end else if (in_range(reg_addr_i, DRIVE_STATE_BASE, DRIVE_STATE_LAST)) begin
                idx = reg_index(reg_addr_i, DRIVE_STATE_BASE);
                for (int j = 0; j < CH_PER_REG; j++) begin
                    ch = int'(idx) * CH_PER_REG + j;
                    st_nxt.drv[ch] = reg_wdata_i[2*j +: 2];
                end
            end else if (in_range(reg_addr_i, PWM_BASE, PWM_LAST)) begin
                idx = reg_index(reg_addr_i, PWM_BASE);
                st_nxt.pwm[idx] = reg_wdata_i;
            end else if (in_range(reg_addr_i, GAIN_BASE, GAIN_LAST)) begin
                idx = reg_index(reg_addr_i, GAIN_BASE);
                st_nxt.gain[idx] = reg_wdata_i;
            end else if (reg_addr_i == GROUP_DUTY_ADDR) begin
                st_nxt.grp_duty = reg_wdata_i;
            end else if (reg_addr_i == GROUP_FREQ_ADDR) begin
                st_nxt.grp_freq = reg_wdata_i;
            end else if (reg_addr_i == TURN_ON_OFFSET_ADDR) begin
                st_nxt.on_offset = reg_wdata_i[3:0];
            end
        end

        // register reads, data shown in the following cycle only
        if (reg_rd_i) begin
            if (reg_addr_i == MODE_CFG_ADDR) begin
                rd = READ_IDLE;
                rd[OVERHEAT_BIT] = hot_s;
                rd[FAULT_ANY_BIT] = fault_any;
                rd[GROUP_BLINK_BIT] = st_r.blink_sel;
                rd[KEEP_DETECT_BIT] = st_r.keep_det;
            end else if (in_range(reg_addr_i, FAULT_FLAG_BASE, FAULT_FLAG_LAST)) begin
                idx = reg_index(reg_addr_i, FAULT_FLAG_BASE);
                for (int j = 0; j < CH_PER_REG; j++) begin
                    ch = int'(idx) * CH_PER_REG + j;
                    rd[2*j +: 2] = st_r.fault[ch];
                end
            end else if (in_range(reg_addr_i, DRIVE_STATE_BASE, DRIVE_STATE_LAST)) begin
                idx = reg_index(reg_addr_i, DRIVE_STATE_BASE);
                for (int j = 0; j < CH_PER_REG; j++) begin
                    ch = int'(idx) * CH_PER_REG + j;
                    rd[2*j +: 2] = st_r.drv[ch];
                end
            end else if (in_range(reg_addr_i, PWM_BASE, PWM_LAST)) begin
                idx = reg_index(reg_addr_i, PWM_BASE);
                rd = st_r.pwm[idx];
            end else if (in_range(reg_addr_i, GAIN_BASE, GAIN_LAST)) begin
                idx = reg_index(reg_addr_i, GAIN_BASE);
                rd = st_r.gain[idx];
            end else if (reg_addr_i == GROUP_DUTY_ADDR) begin
                rd = st_r.grp_duty;
            end else if (reg_addr_i == GROUP_FREQ_ADDR) begin
                rd = st_r.grp_freq;
            end else if (reg_addr_i == TURN_ON_OFFSET_ADDR) begin
                rd = {4'h0, st_r.on_offset};
            end
        end
        st_nxt.rdata = rd;

        // fractional timebase: 256 pwm steps per 640 clocks
        acc_sum = st_r.acc + PWM_ACC_STEP;
        if (acc_sum >= PWM_ACC_MOD) begin
            st_nxt.acc = acc_sum - PWM_ACC_MOD;
            pwm_tick = 1'b1;
        end else begin
            st_nxt.acc = acc_sum;
        end
        if (pwm_tick) begin
            st_nxt.pwm_cnt = st_r.pwm_cnt + 8'h01;
            period_end = (st_r.pwm_cnt == PWM_FULL);
        end

        // group dimming advances once per individual pwm period
        blink_len = ({4'h0, st_r.grp_freq} + 12'h001) * BLINK_PERIODS_W;
        if (period_end) begin
            st_nxt.dim_cnt = st_r.dim_cnt + 8'h01;
            if (st_r.blink_pre >= blink_len - 12'h001) begin
                st_nxt.blink_pre = 12'h000;
                st_nxt.blink_cnt = st_r.blink_cnt + 8'h01;
            end else begin
                st_nxt.blink_pre = st_r.blink_pre + 12'h001;
            end
        end
        if (st_r.blink_sel) begin
            grp_on = st_r.blink_cnt < st_r.grp_duty;
        end else begin
            grp_on = st_r.dim_cnt < st_r.grp_duty;
        end

        // turn-on delay timer restarts whenever the gate pin goes inactive
        if (gate_n_s) begin
            st_nxt.us_pre = 5'h00;
            st_nxt.elapsed = 10'h000;
        end else if (st_r.us_pre == DELAY_UNIT_CYC - 5'h01) begin
            st_nxt.us_pre = 5'h00;
            if (st_r.elapsed != ELAPSED_MAX) begin
                st_nxt.elapsed = st_r.elapsed + 10'h001;
            end
        end else begin
            st_nxt.us_pre = st_r.us_pre + 5'h01;
        end

        halt = !st_r.keep_det && fault_any;

        for (int n = 0; n < NUM_CH; n++) begin
            pwm_on = st_r.pwm_cnt < st_r.pwm[n];
            case (st_r.drv[n])
                DRV_OFF: base_on = 1'b0;
                DRV_ON: base_on = 1'b1;
                DRV_INDIV: base_on = pwm_on;
                DRV_GROUP: base_on = pwm_on && grp_on;
                default: base_on = 1'b0;
            endcase
            threshold = 10'(n) * {6'h00, st_r.on_offset};
            gate_ok = !gate_n_s && (st_r.elapsed >= threshold);
            // drive registers are untouched while hot, so recovery resumes the prior pattern
            st_nxt.sink[n] = base_on && gate_ok && !hot_s;

            // detection needs the channel sinking, a nonzero gain, and drive on or pwm from PWM_TEST_MIN to below full
            detect_ok = st_r.sink[n] && (st_r.gain[n] != 8'h00) &&
                ((st_r.drv[n] == DRV_ON) ||
                 (st_r.drv[n][1] && (st_r.pwm[n] >= PWM_TEST_MIN) && (st_r.pwm[n] != PWM_FULL)));
            if (short_s[n]) begin
                code = FAULT_SHORT;
            end else if (open_s[n]) begin
                code = FAULT_OPEN;
            end else begin
                code = FAULT_NONE;
            end

            if (st_r.keep_det) begin
                if (st_r.drv[n] == DRV_OFF) begin
                    st_nxt.fault[n] = FAULT_NONE;
                end else if (detect_ok) begin
                    st_nxt.fault[n] = code;
                end else if (fault_clear) begin
                    st_nxt.fault[n] = FAULT_NONE;
                end
            end else begin
                if (detect_ok && !halt && (code != FAULT_NONE)) begin
                    st_nxt.fault[n] = code;
                end else if (fault_clear) begin
                    st_nxt.fault[n] = FAULT_NONE;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o = st_r.rdata;
    assign led_sink_o = st_r.sink;
    assign current_gain_o = st_r.gain;
    assign overheat_o = hot_s;
    assign fault_any_o = fault_any;
endmodule

/* File: sim/lfg_led_fault_gate_sva.sv */
// assertions on the led fault and output gate ports
`timescale 1ns/1ps
module lfg_led_fault_gate_sva
    import lfg_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [23:0] open_cmp_i,
    input wire logic [23:0] short_cmp_i,
    input wire logic overheat_flag_i,
    input wire logic out_gate_n_i,
    input wire logic [23:0] led_sink_o,
    input wire logic [23:0][7:0] current_gain_o,
    input wire logic overheat_o,
    input wire logic fault_any_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_gate_high; out_gate_n_i [*4]; endsequence
    sequence s_gate_fall; s_gate_high ##1 !out_gate_n_i; endsequence
    property p_gate_off; s_gate_high |-> led_sink_o == 24'h000000; endproperty
    a_gate_off: assert property (p_gate_off) else $error("sink on with gate high");
    property p_gate_lag; s_gate_fall |-> ##1 (led_sink_o == 24'h000000) [*2]; endproperty
    a_gate_lag: assert property (p_gate_lag) else $error("sink before gate synced");
    property p_hot_flag; overheat_flag_i [*4] |-> overheat_o; endproperty
    a_hot_flag: assert property (p_hot_flag) else $error("overheat flag not set");
    property p_cool_flag; !overheat_flag_i [*4] |-> !overheat_o; endproperty
    a_cool_flag: assert property (p_cool_flag) else $error("overheat flag not cleared");
    property p_hot_off; overheat_o && $past(overheat_o) |-> led_sink_o == 24'h000000; endproperty
    a_hot_off: assert property (p_hot_off) else $error("sink on while hot");
    property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
    property p_no_dne;
        reg_rd_i && reg_addr_i >= FAULT_FLAG_BASE && reg_addr_i <= FAULT_FLAG_LAST
            |=> (reg_rdata_o & (reg_rdata_o >> 1) & 8'h55) == 8'h00;
    endproperty
    a_no_dne: assert property (p_no_dne) else $error("fault code 11 seen");
    property p_status;
        reg_rd_i && reg_addr_i == MODE_CFG_ADDR |=> reg_rdata_o[7:6] == {$past(overheat_o), $past(fault_any_o)};
    endproperty
    a_status: assert property (p_status) else $error("mode status bits wrong");
    property p_gain; reg_wr_i && reg_addr_i == GAIN_BASE |=> current_gain_o[0] == $past(reg_wdata_i); endproperty
    a_gain: assert property (p_gain) else $error("gain output not updated");
    property p_reset_clear;
        disable iff (1'b0) reset_i |=> led_sink_o == 24'h000000 && reg_rdata_o == 8'h00 && !overheat_o
            && !fault_any_o && current_gain_o[0] == 8'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");
endmodule

bind lfg_led_fault_gate lfg_led_fault_gate_sva lfg_led_fault_gate_sva_i (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .open_cmp_i(open_cmp_i), .short_cmp_i(short_cmp_i),
    .overheat_flag_i(overheat_flag_i), .out_gate_n_i(out_gate_n_i), .led_sink_o(led_sink_o),
    .current_gain_o(current_gain_o), .overheat_o(overheat_o), .fault_any_o(fault_any_o));

/* File: sim/lfg_host_model.sv */
// host side model: reset pulse, start-up wait and gate pin drive
`timescale 1ns/1ps
module lfg_host_model
    import lfg_pkg::*;
#(
    parameter int RESET_CYC = 20,
    parameter int WAKE_CYC = 8,
    parameter int PULSE_CYC = 40
) (
    input wire logic ref_clk_i,
    input wire logic do_reset_i,
    input wire logic gate_level_i,
    input wire logic pulse_en_i,
    output logic reset_o,
    output logic ready_o,
    output logic out_gate_n_o
);
    int rst_cnt = RESET_CYC;
    int wake_cnt = WAKE_CYC;
    int pulse_cnt = 0;
    logic pulse_r = 1'b1;
    // reset held for its minimum width, then no access until the wake time is over
    always_ff @(posedge ref_clk_i) begin
        if (do_reset_i) begin
            rst_cnt <= RESET_CYC;
            wake_cnt <= WAKE_CYC;
        end else if (rst_cnt > 0) begin
            rst_cnt <= rst_cnt - 1;
        end else if (wake_cnt > 0) begin
            wake_cnt <= wake_cnt - 1;
        end
        if (!pulse_en_i || pulse_cnt == PULSE_CYC - 1) begin
            pulse_cnt <= 0;
            pulse_r <= pulse_en_i ? ~pulse_r : 1'b1;
        end else begin
            pulse_cnt <= pulse_cnt + 1;
        end
    end
    assign reset_o = rst_cnt > 0;
    assign ready_o = rst_cnt == 0 && wake_cnt == 0;
    // dimming pulse train on the gate; the bench checks it on a channel set fully on
    assign out_gate_n_o = pulse_en_i ? pulse_r : gate_level_i;
endmodule

/* File: sim/tb_lfg_led_fault_gate.sv */
// self-checking bench for led fault flags and output gating
`timescale 1ns/1ps
module tb_lfg_led_fault_gate
    import lfg_pkg::*;
;
    typedef struct {logic [6:0] a; logic [7:0] d; logic [7:0] q;} lfg_row_t;
    logic ref_clk_i = 1'b0;
    logic reset_i;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [6:0] reg_addr_i = 7'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic [23:0] open_cmp_i = 24'hfffffe;
    logic [23:0] short_cmp_i = 24'h000000;
    logic overheat_flag_i = 1'b0;
    logic out_gate_n_i;
    logic [23:0] led_sink_o;
    logic [23:0][7:0] current_gain_o;
    logic overheat_o;
    logic fault_any_o;
    logic do_reset = 1'b0;
    logic gate_level = 1'b1;
    logic pulse_en = 1'b0;
    logic host_ready;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int hi;
    lfg_row_t rows [10] = '{'{MODE_CFG_ADDR, 8'h28, 8'h28}, '{DRIVE_STATE_BASE, 8'h25, 8'h25},
        '{PWM_BASE + 7'h02, 8'h80, 8'h80}, '{GROUP_DUTY_ADDR, 8'h40, 8'h40}, '{GROUP_FREQ_ADDR, 8'h07, 8'h07},
        '{TURN_ON_OFFSET_ADDR, 8'h01, 8'h01}, '{GAIN_BASE, 8'h10, 8'h10}, '{GAIN_LAST, 8'hff, 8'hff},
        '{FAULT_FLAG_BASE + 7'h01, 8'hff, 8'h00}, '{7'h50, 8'h5a, 8'h00}};

    lfg_led_fault_gate lfg_led_fault_gate_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .open_cmp_i(open_cmp_i), .short_cmp_i(short_cmp_i),
        .overheat_flag_i(overheat_flag_i), .out_gate_n_i(out_gate_n_i), .led_sink_o(led_sink_o),
        .current_gain_o(current_gain_o), .overheat_o(overheat_o), .fault_any_o(fault_any_o));
    lfg_host_model lfg_host_model_i (.ref_clk_i(ref_clk_i), .do_reset_i(do_reset), .gate_level_i(gate_level),
        .pulse_en_i(pulse_en), .reset_o(reset_i), .ready_o(host_ready), .out_gate_n_o(out_gate_n_i));

    initial begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic check(input string n, input logic [23:0] s, input logic [23:0] e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e, input string n);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 check(n, reg_rdata_o, e);
    endtask
    task automatic setc(input logic [23:0] o, input logic [23:0] s);
        @(posedge ref_clk_i);
        open_cmp_i <= o;
        short_cmp_i <= s;
        tick(5);
    endtask

    initial begin
        wait (host_ready === 1'b1);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].q, "register");
        end
        check("gain out", {current_gain_o[23], current_gain_o[0]}, 16'hff10);
        $display("test registers done");
        @(posedge ref_clk_i);
        gate_level <= 1'b0;
        tick(10);
        check("delay early", led_sink_o[1:0], 2'b01);
        tick(25);
        check("delay late", led_sink_o[1:0], 2'b11);
        hi = 0;
        repeat (2560) begin
            tick(1);
            hi += led_sink_o[2];
        end
        check("pwm duty", hi > 1270 && hi < 1290, 1'b1);
        $display("test gate and pwm done");
        setc(24'hfffffe, 24'h000001);
        rd(FAULT_FLAG_BASE, 8'h01, "short");
        check("fault any", fault_any_o, 1'b1);
        setc(24'hffffff, 24'h000001);
        rd(FAULT_FLAG_BASE, 8'h01, "short first");
        setc(24'hffffff, 24'h000000);
        rd(FAULT_FLAG_BASE, 8'h02, "open");
        // host turns the faulted channel off, then back on for the later tests
        wr(DRIVE_STATE_BASE, 8'h24);
        rd(FAULT_FLAG_BASE, 8'h00, "off reads zero");
        check("off sink", led_sink_o[0], 1'b0);
        wr(DRIVE_STATE_BASE, 8'h25);
        setc(24'hfffffe, 24'h000000);
        rd(FAULT_FLAG_BASE, 8'h00, "live clear");
        wr(MODE_CFG_ADDR, 8'h20);
        setc(24'hffffff, 24'h000000);
        setc(24'hfffffe, 24'h000001);
        rd(FAULT_FLAG_BASE, 8'h02, "latched");
        wr(MODE_CFG_ADDR, 8'h30);
        tick(5);
        rd(FAULT_FLAG_BASE, 8'h01, "recapture");
        setc(24'hfffffe, 24'h000000);
        wr(MODE_CFG_ADDR, 8'h30);
        tick(5);
        rd(FAULT_FLAG_BASE, 8'h00, "cleared");
        rd(MODE_CFG_ADDR, 8'h20, "mode status");
        $display("test faults done");
        @(posedge ref_clk_i);
        overheat_flag_i <= 1'b1;
        tick(5);
        check("hot sinks", led_sink_o, 24'h000000);
        rd(MODE_CFG_ADDR, 8'ha0, "hot flag");
        @(posedge ref_clk_i);
        overheat_flag_i <= 1'b0;
        tick(40);
        check("restored", led_sink_o[1:0], 2'b11);
        check("flag gone", overheat_o, 1'b0);
        $display("test overheat done");
        @(posedge ref_clk_i);
        pulse_en <= 1'b1;
        hi = 0;
        repeat (800) begin
            tick(1);
            hi += led_sink_o[0];
        end
        check("gate dim", hi > 370 && hi < 430, 1'b1);
        @(posedge ref_clk_i);
        pulse_en <= 1'b0;
        gate_level <= 1'b1;
        tick(4);
        check("gate off", led_sink_o, 24'h000000);
        $display("test gate pin done");
        @(posedge ref_clk_i);
        do_reset <= 1'b1;
        @(posedge ref_clk_i);
        do_reset <= 1'b0;
        @(posedge ref_clk_i);
        wait (host_ready === 1'b1);
        foreach (rows[i]) begin
            rd(rows[i].a, 8'h00, "reset value");
        end
        $display("test reset done");
        print_verdict();
    end
endmodule
